/* File: sim/effective_address_generator_bench.sv */
// self-checking bench for the effective address generator
`timescale 1ns/100ps
module effective_address_generator_bench;
  import ea_pkg::*;
  // one case: operation word, extensions and expected results
  typedef struct {
    logic [15:0] op; size_t sz; logic [2:0] fl; int n;
    logic [15:0] e0; logic [15:0] e1; loc_t xloc;
    logic [31:0] ea; logic [31:0] val; logic pr; logic [31:0] wd;
  } row_t;
  logic mclk = 1'b0; // 40 MHz clock
  logic sys_rst = 1'b1; // async reset
  logic op_valid = 1'b0, ext_valid = 1'b0; // request strobes
  logic jump_instruction = 1'b0, subroutine_call_instruction = 1'b0;
  logic op_write = 1'b0; // operand direction
  logic [15:0] op_word = 16'h0, ext_word = 16'h0; // instruction words
  logic [31:0] op_pc = 32'h100; // operation word address
  size_t op_size = SZ_WORD; // operand size
  logic [31:0] address_reg_n, data_reg_n, index_rd; // from register file
  logic busy, ext_ready, index_is_addr, index_long, done, prog_ref;
  logic areg_we, addr_odd_err;
  logic [2:0] areg_sel, index_sel, instr_words;
  logic [31:0] ea_addr, imm_data, operand, areg_wdata;
  logic [31:0] hi_byte_addr, lo_byte_addr, long_lo_addr;
  loc_t loc; // operand location
  int fails = 0; // mismatches
  int check_count = 0; // comparisons
  row_t rows[22]; // ordinary cases
  row_t pc_row; // pc-relative case with a moved program counter

  always #12.5 mclk = ~mclk;

  ea_gen dut (.mclk, .sys_rst, .op_valid, .op_word, .op_pc, .op_size,
    .op_write, .jump_instruction, .subroutine_call_instruction, .ext_valid,
    .ext_word, .address_reg_n, .data_reg_n, .index_rd, .busy, .ext_ready,
    .areg_sel, .index_sel, .index_is_addr, .index_long, .done, .loc,
    .ea_addr, .imm_data, .operand, .prog_ref, .instr_words, .areg_we,
    .areg_wdata, .addr_odd_err, .hi_byte_addr, .lo_byte_addr,
    .long_lo_addr);
  reg_file_model partner (.reg_no(op_word[2:0]), .index_sel,
    .index_is_addr, .index_long, .address_reg_n, .data_reg_n, .index_rd);

  // one comparison, reported at once on mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // counts, verdict and end of run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // present the operation word for one edge; returns at the taking edge
  task automatic start(input row_t r);
    @(posedge mclk);
    op_valid <= 1'b1;
    op_word <= r.op;
    op_size <= r.sz;
    {jump_instruction, subroutine_call_instruction, op_write} <= r.fl;
    @(posedge mclk);
    op_valid <= 1'b0;
  endtask

  // hold one extension word until an edge sees ext_ready high
  task automatic send(input logic [15:0] w);
    int k;
    ext_valid <= 1'b1;
    ext_word <= w;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (ext_ready !== 1'b1 && k < 20);
    if (k >= 20) fails++;
  endtask

  // bounded wait for the done pulse, sampled after the edge settles
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (done !== 1'b1 && k < 20);
    if (done !== 1'b1) fails++;
  endtask

  // run one case and compare everything it fixes
  task automatic run_row(input row_t r);
    logic [31:0] wa; // word address holding the operand
    logic odd; // word or long access at an odd byte
    start(r);
    if (r.n > 0) send(r.e0);
    if (r.n > 1) send(r.e1);
    ext_valid <= 1'b0;
    wait_done();
    chk({30'h0, loc}, {30'h0, r.xloc});
    chk(ea_addr, r.ea);
    chk({29'h0, instr_words}, 32'(r.n + 1));
    chk({29'h0, areg_sel}, {29'h0, r.op[2:0]});
    chk({31'h0, areg_we}, {31'h0, r.wd != 32'h0});
    if (r.wd != 32'h0) chk(areg_wdata, r.wd);
    if (r.xloc == LOC_DREG || r.xloc == LOC_AREG)
      chk(operand, r.val);
    if (r.xloc == LOC_IMM) chk(imm_data, r.val);
    if (r.xloc == LOC_MEM) begin
      // byte lanes sit on the even word that holds the operand
      wa = {r.ea[31:1], 1'b0};
      odd = r.sz != SZ_BYTE && r.ea[0];
      chk({31'h0, prog_ref}, {31'h0, r.pr});
      chk(hi_byte_addr, wa);
      chk(lo_byte_addr, wa + 32'h1);
      chk(long_lo_addr, wa + 32'h2);
      chk({31'h0, addr_odd_err}, {31'h0, odd});
    end
  endtask

  // hang guard, far beyond the expected run length
  initial begin
    repeat (4000) @(posedge mclk);
    fails++;
    print_verdict();
  end

  initial begin
    rows = '{
      '{16'h0002, SZ_WORD, 3'h0, 0, 16'h0, 16'h0, LOC_DREG, 0, 32'h12, 0, 0},
      '{16'h000d, SZ_LONG, 3'h0, 0, 16'h0, 16'h0, LOC_AREG, 0, 32'h1500, 0, 0},
      '{16'h0011, SZ_WORD, 3'h0, 0, 16'h0, 16'h0, LOC_MEM, 32'h1100, 0, 0, 0},
      '{16'h001b, SZ_LONG, 3'h0, 0, 16'h0, 16'h0, LOC_MEM, 32'h1300, 0, 0,
        32'h1304},
      '{16'h001f, SZ_BYTE, 3'h0, 0, 16'h0, 16'h0, LOC_MEM, 32'h1700, 0, 0,
        32'h1702},
      '{16'h0022, SZ_WORD, 3'h0, 0, 16'h0, 16'h0, LOC_MEM, 32'h11fe, 0, 0,
        32'h11fe},
      '{16'h0027, SZ_BYTE, 3'h0, 0, 16'h0, 16'h0, LOC_MEM, 32'h16fe, 0, 0,
        32'h16fe},
      '{16'h0024, SZ_BYTE, 3'h0, 0, 16'h0, 16'h0, LOC_MEM, 32'h13ff, 0, 0,
        32'h13ff},
      '{16'h0029, SZ_WORD, 3'h0, 1, 16'hfff0, 16'h0, LOC_MEM, 32'h10f0, 0, 0, 0},
      '{16'h0030, SZ_WORD, 3'h0, 1, 16'h30fe, 16'h0, LOC_MEM, 32'hffff8ffe, 0,
        0, 0},
      '{16'h0038, SZ_WORD, 3'h0, 1, 16'h8000, 16'h0, LOC_MEM, 32'hffff8000, 0,
        0, 0},
      '{16'h0039, SZ_LONG, 3'h0, 2, 16'h0012, 16'h3456, LOC_MEM, 32'h123456, 0,
        0, 0},
      '{16'h003a, SZ_WORD, 3'h0, 1, 16'h0010, 16'h0, LOC_MEM, 32'h112, 0, 1, 0},
      '{16'h003b, SZ_LONG, 3'h0, 1, 16'ha804, 16'h0, LOC_MEM, 32'h1306, 0, 1, 0},
      '{16'h003c, SZ_BYTE, 3'h0, 1, 16'h12ab, 16'h0, LOC_IMM, 0, 32'hab, 0, 0},
      '{16'h003c, SZ_WORD, 3'h0, 1, 16'hbeef, 16'h0, LOC_IMM, 0, 32'hbeef, 0, 0},
      '{16'h003c, SZ_LONG, 3'h0, 2, 16'hdead, 16'hbeef, LOC_IMM, 0,
        32'hdeadbeef, 0, 0},
      '{16'h0011, SZ_LONG, 3'h4, 0, 16'h0, 16'h0, LOC_MEM, 32'h1100, 0, 1, 0},
      '{16'h0029, SZ_WORD, 3'h4, 1, 16'hfff0, 16'h0, LOC_MEM, 32'h10f0, 0, 0, 0},
      '{16'h0029, SZ_WORD, 3'h2, 1, 16'hfff0, 16'h0, LOC_MEM, 32'h10f0, 0, 1, 0},
      '{16'h003a, SZ_WORD, 3'h1, 1, 16'h0010, 16'h0, LOC_MEM, 32'h112, 0, 0, 0},
      '{16'h0038, SZ_WORD, 3'h0, 1, 16'h0101, 16'h0, LOC_MEM, 32'h101, 0, 0, 0}
    };
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk({29'h0, instr_words}, 32'h1);
    chk({30'h0, busy, done}, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      run_row(rows[i]);
      $display("row %0d done", i);
    end
    // stray word while idle, then a start request while busy
    @(posedge mclk);
    ext_valid <= 1'b1;
    ext_word <= 16'h7777;
    @(posedge mclk);
    ext_valid <= 1'b0;
    #1;
    chk({30'h0, busy, ext_ready}, 32'h0);
    start(rows[11]);
    send(16'h0012);
    op_valid <= 1'b1;
    send(16'h3456);
    op_valid <= 1'b0;
    ext_valid <= 1'b0;
    wait_done();
    chk(ea_addr, 32'h123456);
    @(posedge mclk);
    #1;
    chk({31'h0, busy}, 32'h0);
    $display("refusal test done");
    // reset in mid-sequence, then a clean run
    start(rows[11]);
    send(16'h0012);
    ext_valid <= 1'b0;
    sys_rst <= 1'b1;
    @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk({30'h0, busy, done}, 32'h0);
    run_row(rows[9]);
    $display("abort test done");
    // moved program counter shifts the pc-relative target with it
    @(posedge mclk);
    op_pc <= 32'h2000;
    pc_row = rows[12];
    pc_row.ea = 32'h2012;
    run_row(pc_row);
    $display("pc move test done");
    print_verdict();
  end
endmodule

/* File: sim/reg_file_model.sv */
// register file model that feeds the effective address generator
`timescale 1ns/100ps
module reg_file_model (
  input wire logic [2:0] reg_no,
  input wire logic [2:0] index_sel,
  input wire logic index_is_addr,
  input wire logic index_long,
  output logic [31:0] address_reg_n,
  output logic [31:0] data_reg_n,
  output logic [31:0] index_rd
);
  logic [31:0] areg [8]; // address registers, fixed contents
  logic [31:0] dreg [8]; // data registers, fixed contents
  logic [31:0] ix_raw; // index before word sizing

  // preset contents; one data word is negative to test sign extension
  initial begin
    for (int i = 0; i < 8; i++) begin
      areg[i] = 32'h1000 + 32'(i) * 32'h100;
      dreg[i] = 32'h10 + 32'(i);
    end
    dreg[3] = 32'h1234_8000;
  end

  // reads are combinational, so no stale value outlives a select change
  always_comb begin
    address_reg_n = areg[reg_no];
    data_reg_n = dreg[reg_no];
    ix_raw = index_is_addr ? areg[index_sel] : dreg[index_sel];
    // word index is sign-extended here, not in the generator
    index_rd = index_long ? ix_raw : {{16{ix_raw[15]}}, ix_raw[15:0]};
  end
endmodule

/* File: src/ea_calc.sv */
// combinational address adder for extension-word modes
`timescale 1ns/100ps
module ea_calc
  import ea_pkg::*;
(
  ea_if.calc e
);
  // sign extension of an 8 bit displacement
  function automatic logic [31:0] sx8(input logic [7:0] v);
    sx8 = {{24{v[7]}}, v};
  endfunction
  // sign extension of a 16 bit value
  function automatic logic [31:0] sx16(input logic [15:0] v);
    sx16 = {{16{v[15]}}, v};
  endfunction

  // address formation per mode
  always_comb begin
    e.addr = e.base;
    unique case (e.mode)
      MODE_DISP: e.addr = e.base + sx16(e.ext0);
      MODE_IDX: e.addr = e.base + e.index + sx8(e.ext0[7:0]);
      MODE_SPEC: begin
        unique case (e.reg_no)
          SPEC_ABS_S: e.addr = sx16(e.ext0);
          SPEC_ABS_L: e.addr = {e.ext0, e.ext1};
          SPEC_PC_D: e.addr = e.ext_pc + sx16(e.ext0);
          SPEC_PC_X: e.addr = e.ext_pc + e.index + sx8(e.ext0[7:0]);
          default: e.addr = e.base;
        endcase
      end
      default: e.addr = e.base;
    endcase
  end
endmodule

/* File: src/ea_gen.sv */
// effective address generator for a single-operand operation word
`timescale 1ns/100ps
module ea_gen
  import ea_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  // operation word and start strobe
  input wire logic op_valid,
  input wire logic [15:0] op_word,
  input wire logic [31:0] op_pc,
  input wire size_t op_size,
  input wire logic op_write,
  input wire logic jump_instruction,
  input wire logic subroutine_call_instruction,
  // extension word stream
  input wire logic ext_valid,
  input wire logic [15:0] ext_word,
  // register file read data
  input wire logic [31:0] address_reg_n,
  input wire logic [31:0] data_reg_n,
  input wire logic [31:0] index_rd,
  // results
  output logic busy,
  output logic ext_ready,
  output logic [2:0] areg_sel,
  output logic [2:0] index_sel,
  output logic index_is_addr,
  output logic index_long,
  output logic done,
  output loc_t loc,
  output logic [31:0] ea_addr,
  output logic [31:0] imm_data,
  output logic [31:0] operand,
  output logic prog_ref,
  output logic [2:0] instr_words,
  output logic areg_we,
  output logic [31:0] areg_wdata,
  output logic addr_odd_err,
  output logic [31:0] hi_byte_addr,
  output logic [31:0] lo_byte_addr,
  output logic [31:0] long_lo_addr
);
  // sequencer states
  typedef enum logic [2:0] {
    S_IDLE, S_EXT0, S_EXT1, S_CALC, S_DONE
  } st_t;

  // extension word count required by the effective address
  function automatic logic [1:0] ext_count(input logic [2:0] m,
      input logic [2:0] r, input size_t sz);
    ext_count = 2'h0;
    unique case (m)
      MODE_DISP, MODE_IDX: ext_count = 2'h1;
      MODE_SPEC: begin
        unique case (r)
          SPEC_ABS_S, SPEC_PC_D, SPEC_PC_X: ext_count = 2'h1;
          SPEC_ABS_L: ext_count = 2'h2;
          SPEC_IMM: ext_count = (sz == SZ_LONG) ? 2'h2 : 2'h1;
          default: ext_count = 2'h0;
        endcase
      end
      default: ext_count = 2'h0;
    endcase
  endfunction

  // address step by operand size
  function automatic logic [31:0] step(input size_t sz,
      input logic [2:0] r);
    unique case (sz)
      SZ_LONG: step = 32'h4;
      SZ_WORD: step = 32'h2;
      // byte steps by two on the stack pointer to keep it even
      default: step = (r == SP_REG) ? 32'h2 : 32'h1;
    endcase
  endfunction

  st_t st_q;
  logic [2:0] mode_q; // latched mode field
  logic [2:0] reg_q; // latched register field
  size_t size_q; // latched operand size
  logic write_q; // operand is a write
  logic jmp_q; // jump instruction
  logic jsr_q; // subroutine call
  logic [1:0] need_q; // extension words expected for this operand
  logic [15:0] ext0_q; // first extension word
  logic [15:0] ext1_q; // second extension word
  logic [31:0] ext_pc_q; // address of first extension word
  logic [31:0] base_q; // captured address register
  logic [31:0] calc_addr; // adder result
  logic [31:0] mem_addr; // final memory address
  logic [31:0] ea_d; // next ea_addr
  logic pref_d; // next program reference flag
  logic mem_mode; // operand lives in memory

  ea_if e ();
  assign e.mode = mode_q;
  assign e.reg_no = reg_q;
  assign e.ext0 = ext0_q;
  assign e.ext1 = ext1_q;
  assign e.ext_pc = ext_pc_q;
  assign e.base = base_q;
  assign e.index = index_rd;
  assign calc_addr = e.addr;

  ea_calc u_calc (
    .e(e)
  );

  // sequencer: opword, extension words, result
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      need_q <= 2'h0;
    end else begin
      unique case (st_q)
        S_IDLE: begin
          if (op_valid) begin
            need_q <= ext_count(op_word[EA_MODE_HI:EA_MODE_LO],
              op_word[EA_REG_HI:EA_REG_LO], op_size);
            if (ext_count(op_word[EA_MODE_HI:EA_MODE_LO],
                op_word[EA_REG_HI:EA_REG_LO], op_size) != 2'h0) begin
              st_q <= S_EXT0;
            end else begin
              st_q <= S_CALC;
            end
          end
        end
        S_EXT0: begin
          if (ext_valid) begin
            st_q <= (need_q == 2'h2) ? S_EXT1 : S_CALC;
          end
        end
        S_EXT1: begin
          if (ext_valid) begin
            st_q <= S_CALC;
          end
        end
        S_CALC: st_q <= S_DONE;
        S_DONE: st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // operation word field capture
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      mode_q <= MODE_DREG;
      reg_q <= 3'h0;
      size_q <= SZ_BYTE;
      write_q <= 1'b0;
      jmp_q <= 1'b0;
      jsr_q <= 1'b0;
      ext_pc_q <= ADDR_RST;
      instr_words <= 3'h1;
    end else if (st_q == S_IDLE && op_valid) begin
      // fields at bits 5..3 and 2..0
      mode_q <= op_word[EA_MODE_HI:EA_MODE_LO];
      reg_q <= op_word[EA_REG_HI:EA_REG_LO];
      size_q <= op_size;
      write_q <= op_write;
      jmp_q <= jump_instruction;
      jsr_q <= subroutine_call_instruction;
      // extension word follows at next even address
      ext_pc_q <= op_pc + WORD_STEP;
      instr_words <= 3'h1 + {1'b0, ext_count(op_word[EA_MODE_HI:EA_MODE_LO],
        op_word[EA_REG_HI:EA_REG_LO], op_size)};
    end
  end

  // extension word capture
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ext0_q <= 16'h0;
      ext1_q <= 16'h0;
    end else if (st_q == S_EXT0 && ext_valid) begin
      ext0_q <= ext_word;
    end else if (st_q == S_EXT1 && ext_valid) begin
      ext1_q <= ext_word;
    end
  end

  // address register capture, latched before any update
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      base_q <= ADDR_RST;
    end else if (st_q == S_IDLE && op_valid) begin
      base_q <= address_reg_n;
    end
  end

  // register selects; register number from field
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      areg_sel <= 3'h0;
      index_sel <= 3'h0;
      index_is_addr <= 1'b0;
      index_long <= 1'b0;
    end else begin
      if (st_q == S_IDLE && op_valid) begin
        areg_sel <= op_word[EA_REG_HI:EA_REG_LO];
      end
      if (st_q == S_EXT0 && ext_valid) begin
        index_sel <= ext_word[IX_REG_HI:IX_REG_LO];
        index_is_addr <= ext_word[IX_DA_BIT];
        index_long <= ext_word[IX_LONG_BIT];
      end
    end
  end

  assign mem_mode = (mode_q >= MODE_IND && mode_q <= MODE_IDX) ||
    (mode_q == MODE_SPEC && reg_q <= SPEC_PC_X);

  // memory address choice by mode
  always_comb begin
    unique case (mode_q)
      MODE_IND: mem_addr = base_q;
      MODE_POST: mem_addr = base_q;
      MODE_PRE: mem_addr = base_q - step(size_q, reg_q);
      default: mem_addr = calc_addr;
    endcase
    ea_d = mem_mode ? mem_addr : ADDR_RST;
  end

  // reference class; writes always to data space
  always_comb begin
    pref_d = 1'b0;
    if (!write_q) begin
      // pc relative is a program reference
      if (mode_q == MODE_SPEC &&
          (reg_q == SPEC_PC_D || reg_q == SPEC_PC_X)) begin
        pref_d = 1'b1;
      end else if (mode_q == MODE_DISP) begin
        pref_d = jsr_q;
      end else if (mode_q == MODE_IND || mode_q == MODE_IDX ||
          (mode_q == MODE_SPEC && reg_q <= SPEC_ABS_L)) begin
        // jump and call make program references
        pref_d = jmp_q || jsr_q;
      end
    end
  end

  // result outputs
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      done <= 1'b0;
      loc <= LOC_DREG;
      ea_addr <= ADDR_RST;
      prog_ref <= 1'b0;
      addr_odd_err <= 1'b0;
    end else begin
      done <= (st_q == S_CALC);
      if (st_q == S_CALC) begin
        unique case (mode_q)
          MODE_DREG: loc <= LOC_DREG;
          MODE_AREG: loc <= LOC_AREG;
          MODE_SPEC: loc <= (reg_q == SPEC_IMM) ? LOC_IMM : LOC_MEM;
          default: loc <= LOC_MEM;
        endcase
        ea_addr <= ea_d;
        prog_ref <= pref_d;
        // word and long accesses must be even
        addr_odd_err <= mem_mode && size_q != SZ_BYTE && ea_d[0];
      end
    end
  end

  // byte lane addresses; high byte even, low odd
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hi_byte_addr <= ADDR_RST;
      lo_byte_addr <= ADDR_RST;
      long_lo_addr <= ADDR_RST;
    end else if (st_q == S_CALC) begin
      hi_byte_addr <= {ea_d[31:1], 1'b0};
      lo_byte_addr <= {ea_d[31:1], 1'b1};
      // second word at n + 2
      long_lo_addr <= {ea_d[31:1], 1'b0} + WORD_STEP;
    end
  end

  // operand and immediate data
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      operand <= 32'h0;
      imm_data <= 32'h0;
    end else if (st_q == S_CALC) begin
      operand <= (mode_q == MODE_AREG) ? base_q : data_reg_n;
      unique case (size_q)
        SZ_BYTE: imm_data <= {24'h0, ext0_q[7:0]};
        SZ_WORD: imm_data <= {16'h0, ext0_q};
        default: imm_data <= {ext0_q, ext1_q};
      endcase
    end
  end

  // address register write-back for increment and decrement
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      areg_we <= 1'b0;
      areg_wdata <= ADDR_RST;
    end else begin
      areg_we <= 1'b0;
      if (st_q == S_CALC && mode_q == MODE_POST) begin
        areg_we <= 1'b1;
        areg_wdata <= base_q + step(size_q, reg_q);
      end else if (st_q == S_CALC && mode_q == MODE_PRE) begin
        areg_we <= 1'b1;
        areg_wdata <= base_q - step(size_q, reg_q);
      end
    end
  end

  // handshake flags
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      busy <= 1'b0;
      ext_ready <= 1'b0;
    end else begin
      busy <= !(st_q == S_IDLE && !op_valid) && st_q != S_DONE;
      ext_ready <= (st_q == S_IDLE && op_valid &&
        ext_count(op_word[EA_MODE_HI:EA_MODE_LO],
        op_word[EA_REG_HI:EA_REG_LO], op_size) != 2'h0) ||
        (st_q == S_EXT0 && ext_valid && need_q == 2'h2) ||
        (st_q == S_EXT0 && !ext_valid) || (st_q == S_EXT1 && !ext_valid);
    end
  end

  // extension sequence named pieces
  sequence calc_seq;
    st_q == S_CALC;
  endsequence
  sequence done_seq;
    done;
  endsequence

  pc_prog_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_q == S_CALC && mode_q == MODE_SPEC && reg_q == SPEC_PC_D &&
     !write_q) |=> prog_ref && ea_addr == ext_pc_q + {{16{ext0_q[15]}},
     ext0_q})
    else $error("pc displacement address or class wrong");
  post_inc_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_q == S_CALC && mode_q == MODE_POST) |=> areg_we &&
    areg_wdata == $past(base_q) + ((size_q == SZ_LONG) ? 32'h4 :
    (size_q == SZ_WORD || reg_q == SP_REG) ? 32'h2 : 32'h1))
    else $error("post-increment step wrong");
  pre_dec_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_q == S_CALC && mode_q == MODE_PRE) |=>
    areg_we && ea_addr == areg_wdata)
    else $error("pre-decrement address differs from write-back");
  ind_addr_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_q == S_CALC && mode_q == MODE_IND) |=> ea_addr == $past(base_q))
    else $error("indirect address altered");
  abs_long_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_q == S_CALC && mode_q == MODE_SPEC && reg_q == SPEC_ABS_L) |=>
    ea_addr == {$past(ext0_q), $past(ext1_q)})
    else $error("absolute long halves swapped");
  write_data_a: assert property (@(posedge mclk)
    disable iff (sys_rst) (st_q == S_CALC && write_q) |=> !prog_ref)
    else $error("write marked as program reference");
  len_max_a: assert property (@(posedge mclk) disable iff (sys_rst)
    instr_words >= 3'h1 && instr_words <= MAX_WORDS)
    else $error("instruction length out of range");
  done_seq_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (st_q == S_IDLE && op_valid) |-> ##[1:8] calc_seq ##1 done_seq
    or (st_q == S_IDLE && op_valid && ext_count(op_word[5:3],
    op_word[2:0], op_size) != 2'h0))
    else $error("no-extension operand did not finish");
  long_pair_a: assert property (@(posedge mclk)
    disable iff (sys_rst) done |-> long_lo_addr == hi_byte_addr + WORD_STEP)
    else $error("second word not at n plus two");
endmodule

/* File: src/ea_if.sv */
// extension word hand-off between the sequencer and the adder
`timescale 1ns/100ps
interface ea_if;
  logic [2:0] mode; // latched mode field
  logic [2:0] reg_no; // latched register field
  logic [15:0] ext0; // first extension word
  logic [15:0] ext1; // second extension word
  logic [31:0] ext_pc; // address of first extension word
  logic [31:0] base; // selected address register
  logic [31:0] index; // index register value
  logic [31:0] addr; // computed address
  modport seq (output mode, reg_no, ext0, ext1, ext_pc, base, index,
    input addr);
  modport calc (input mode, reg_no, ext0, ext1, ext_pc, base, index,
    output addr);
endinterface

/* File: src/ea_pkg.sv */
// constants and types for the effective address generator
package ea_pkg;
  // mode field codes
  localparam logic [2:0] MODE_DREG = 3'h0;
  localparam logic [2:0] MODE_AREG = 3'h1;
  localparam logic [2:0] MODE_IND = 3'h2;
  localparam logic [2:0] MODE_POST = 3'h3;
  localparam logic [2:0] MODE_PRE = 3'h4;
  localparam logic [2:0] MODE_DISP = 3'h5;
  localparam logic [2:0] MODE_IDX = 3'h6;
  localparam logic [2:0] MODE_SPEC = 3'h7;
  // register field codes under the special mode
  localparam logic [2:0] SPEC_ABS_S = 3'h0;
  localparam logic [2:0] SPEC_ABS_L = 3'h1;
  localparam logic [2:0] SPEC_PC_D = 3'h2;
  localparam logic [2:0] SPEC_PC_X = 3'h3;
  localparam logic [2:0] SPEC_IMM = 3'h4;
  // field positions in the operation word
  localparam int EA_MODE_HI = 5;
  localparam int EA_MODE_LO = 3;
  localparam int EA_REG_HI = 2;
  localparam int EA_REG_LO = 0;
  // index extension word fields
  localparam int IX_DA_BIT = 15;
  localparam int IX_REG_HI = 14;
  localparam int IX_REG_LO = 12;
  localparam int IX_LONG_BIT = 11;
  // stack pointer register number
  localparam logic [2:0] SP_REG = 3'h7;
  // step to the second word of a long operand
  localparam logic [31:0] WORD_STEP = 32'h2;
  // largest instruction length in words
  localparam logic [2:0] MAX_WORDS = 3'h5;
  // reset values
  localparam logic [31:0] ADDR_RST = 32'h0;
  // operand sizes
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} size_t;
  // operand location kinds
  typedef enum logic [1:0] {
    LOC_DREG, LOC_AREG, LOC_MEM, LOC_IMM
  } loc_t;
endpackage
